// *** logic/line_event_irq_pkg.sv ***
// Constants, register indices and types for the line/event interrupt enable block
package line_event_irq_pkg;
   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [7:0] IDX_HDR_FIRST = 8'h15;
   localparam logic [7:0] IDX_HDR_LAST = 8'h28;
   localparam logic [7:0] IDX_LINE_EN = 8'h2d;
   localparam logic [7:0] IDX_EVENT_EN = 8'h2e;
   localparam logic [7:0] IDX_OVFL_EN = 8'h2f;
   localparam logic [7:0] IDX_CELL_EN = 8'h30;
   localparam logic [7:0] IDX_RX_K1K2 = 8'h33;
   localparam logic [7:0] IDX_LINE_ST = 8'h38;
   localparam logic [7:0] IDX_EVENT_ST = 8'h39;
   localparam logic [7:0] IDX_OVFL_ST = 8'h3a;
   localparam logic [7:0] IDX_CELL_ST = 8'h3b;
   localparam logic [7:0] IDX_CONFIG = 8'h40;
   localparam int HDR_REGS = 20;
   // Offsets inside the header register array
   localparam int HDR_MSK_BASE = 8;
   localparam int IDLE_VAL_BASE = 16;
   localparam int IDLE_HEADER_MASK_BASE = 18;
   localparam int NUM_PORTS = 4;

   // ==========================================================
   // Field positions
   localparam int LINE_LOS_BIT = 0;
   localparam int LINE_SEC_BIT = 14;
   localparam int LINE_FEBE_BIT = 15;
   localparam int EV_HOLD_BIT = 15;
   localparam int EV_APS_BIT = 12;
   localparam int EV_SOC_BIT = 11;
   localparam int EV_PAR_LSB = 7;
   localparam int EV_IDLE_BIT = 6;
   localparam int EV_NOMATCH_BIT = 5;
   localparam int EV_GFC_BIT = 4;
   localparam int EV_LEN_BIT = 3;
   localparam int EV_CRC_BIT = 2;
   localparam int EV_HEC_UNC_BIT = 1;
   localparam int EV_HEC_COR_BIT = 0;
   localparam logic [15:0] EV_RESERVED_MASK = 16'h6000;
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_PARITY_BIT = 3;

   // ==========================================================
   // Reset values
   localparam logic [15:0] ENABLE_RESET = 16'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] CONFIG_RESET = 16'h0000;
   localparam logic [7:0] K_RESET = 8'h00;

   typedef enum logic [2:0] {
      MODE_EXT_FRAMER,
      MODE_DS3,
      MODE_E3_G751,
      MODE_SONET,
      MODE_E3E4_G832
   } line_mode_t;
endpackage : line_event_irq_pkg

// *** logic/line_event_irq_enable.sv ***
// Status/enable registers and the shared status interrupt behind an APB slave
// Summary of operation
// - Interrupt output high while any status bit and its same-position enable are set.
// - Four enable registers, indices 0x2D to 0x30, OR into one interrupt output.
// - Line enable at 0x2D gates line status at 0x38.
// - Event enable at 0x2E gates event status at 0x39.
// - Line bit meanings follow the selected line interface mode.
// - Event bit 15 records a high level on the receiver hold pin.
// - Event bit 12 records a change of received K1 or K2 byte.
// - Event bit 11 records a start-of-cell error on FIFO control bit 0.
// - Event bits 10..7 record parity errors of ports 3..0 when checking enabled.
// - Event bit 6 records a cell header matching the idle value under mask.
// - Event bit 5 records a header matching none of the four port filters.
// - Event bit 4 records a cell with non-zero GFC field.
// - Event bit 3 records a trailer payload length error.
// - Event bit 2 records a trailer payload CRC error.
// - Event bit 1 records an uncorrectable header check error.
// - Event bit 0 records a corrected header check error.
// - A change in the last received K1 byte sets event bit 12.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module line_event_irq_enable
   import line_event_irq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic receiver_hold_in,
   input wire logic fifo_control_in_bit0,
   input wire logic loss_of_signal_in,
   input wire logic one_second_tick,
   input wire logic [15:0] line_event_in,
   input wire logic [3:0] parity_error_in,
   input wire logic rx_k_valid,
   input wire logic [7:0] rx_k1_in,
   input wire logic [7:0] rx_k2_in,
   input wire logic cell_hdr_valid,
   input wire logic [31:0] cell_hdr,
   input wire logic payload_len_error,
   input wire logic payload_crc_error,
   input wire logic hec_uncorrected,
   input wire logic hec_corrected,
   input wire logic [15:0] ovfl_status_in,
   input wire logic [15:0] cell_status_in,
   output logic stat_int
);

   // ==========================================================
   // Pin synchronisers: three stages, a level counts once 2nd and 3rd agree
   // A pin pulse shorter than two clocks never reaches the status
   logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
         pin_s3_q <= 3'h0;
      end else begin
         pin_s1_q <= {loss_of_signal_in, fifo_control_in_bit0, receiver_hold_in};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_lvl_q <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (pin_s2_q[i] == pin_s3_q[i]) begin
               pin_lvl_q[i] <= pin_s3_q[i];
            end
         end
      end
   end

   // ==========================================================
   // Registers
   logic [15:0] line_en_q, event_en_q, ovfl_en_q, cell_en_q;
   logic [15:0] line_st_q, event_st_q;
   logic [15:0] config_q;
   logic [15:0] hdr_q [HDR_REGS];
   logic [7:0] rx_k1_q, rx_k2_q;
   logic k_seen_q;
   line_mode_t line_mode;
   logic parity_check_en;

   assign line_mode = line_mode_t'(config_q[CFG_MODE_LSB +: 3]);
   assign parity_check_en = config_q[CFG_PARITY_BIT];

   // ==========================================================
   // APB decode: one access cycle, answer prepared in the setup cycle
   logic [7:0] idx;
   logic addr_ok, setup_ph, wr_go;
   logic is_hdr;
   logic [4:0] hdr_sel;
   logic [15:0] rd_val;
   logic rd_hit;

   assign idx = paddr[9:2];
   assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
   assign setup_ph = psel && !penable;
   assign is_hdr = (idx >= IDX_HDR_FIRST) && (idx <= IDX_HDR_LAST);
   assign hdr_sel = 5'(idx - IDX_HDR_FIRST);
   assign wr_go = psel && penable && pready && pwrite && !pslverr;

   always_comb begin
      rd_val = 16'h0000;
      rd_hit = addr_ok;
      if (is_hdr) begin
         rd_val = hdr_q[hdr_sel];
      end else begin
         unique case (idx)
            IDX_LINE_EN: rd_val = line_en_q;
            IDX_EVENT_EN: rd_val = event_en_q;
            IDX_OVFL_EN: rd_val = ovfl_en_q;
            IDX_CELL_EN: rd_val = cell_en_q;
            IDX_RX_K1K2: rd_val = {rx_k1_q, rx_k2_q};
            IDX_LINE_ST: rd_val = line_st_q;
            IDX_EVENT_ST: rd_val = event_st_q;
            IDX_OVFL_ST: rd_val = ovfl_status_in;
            IDX_CELL_ST: rd_val = cell_status_in;
            IDX_CONFIG: rd_val = config_q;
            default: rd_hit = 1'b0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (setup_ph) begin
         pready <= 1'b1;
         pslverr <= !rd_hit;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Read data holds until the next setup; refused reads give zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_ph) begin
         prdata <= (pwrite || !rd_hit) ? 32'h0000_0000 : {16'h0000, rd_val};
      end
   end

   // ==========================================================
   // Enable and configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_en_q <= ENABLE_RESET;
         event_en_q <= ENABLE_RESET;
         ovfl_en_q <= ENABLE_RESET;
         cell_en_q <= ENABLE_RESET;
      end else if (wr_go) begin
         if (idx == IDX_LINE_EN) line_en_q <= pwdata[15:0];
         // Reserved bits are never stored, so they read back zero
         if (idx == IDX_EVENT_EN) event_en_q <= pwdata[15:0] & ~EV_RESERVED_MASK;
         if (idx == IDX_OVFL_EN) ovfl_en_q <= pwdata[15:0];
         if (idx == IDX_CELL_EN) cell_en_q <= pwdata[15:0];
      end
   end

   // Bits above the mode and parity fields are not stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_q <= CONFIG_RESET;
      end else if (wr_go && idx == IDX_CONFIG) begin
         config_q <= {12'h000, pwdata[3:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < HDR_REGS; i++) begin
            hdr_q[i] <= 16'h0000;
         end
      end else if (wr_go && is_hdr) begin
         hdr_q[hdr_sel] <= pwdata[15:0];
      end
   end

   // ==========================================================
   // Header screening: port filters, idle filter, GFC
   logic [NUM_PORTS-1:0] port_match;
   logic idle_match;
   logic [31:0] idle_val, idle_header_mask;

   generate
      for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
         logic [31:0] val, msk;
         assign val = {hdr_q[2*p], hdr_q[2*p+1]};
         assign msk = {hdr_q[HDR_MSK_BASE+2*p], hdr_q[HDR_MSK_BASE+2*p+1]};
         // A set mask bit makes that header bit a don't-care
         assign port_match[p] = ((cell_hdr ^ val) & ~msk) == 32'h0000_0000;
      end
   endgenerate

   assign idle_val = {hdr_q[IDLE_VAL_BASE], hdr_q[IDLE_VAL_BASE+1]};
   assign idle_header_mask = {hdr_q[IDLE_HEADER_MASK_BASE], hdr_q[IDLE_HEADER_MASK_BASE+1]};
   assign idle_match = ((cell_hdr ^ idle_val) & ~idle_header_mask) == 32'h0000_0000;

   // ==========================================================
   // APS byte tracking: the first frame only loads, it is no change
   logic k_change;
   assign k_change = rx_k_valid && k_seen_q && ((rx_k1_in != rx_k1_q) || (rx_k2_in != rx_k2_q));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_k1_q <= K_RESET;
         rx_k2_q <= K_RESET;
         k_seen_q <= 1'b0;
      end else if (rx_k_valid) begin
         rx_k1_q <= rx_k1_in;
         rx_k2_q <= rx_k2_in;
         k_seen_q <= 1'b1;
      end
   end

   // ==========================================================
   // Event sources
   logic [15:0] event_set, line_set, line_live;

   always_comb begin
      event_set = 16'h0000;
      event_set[EV_HOLD_BIT] = pin_lvl_q[0];
      event_set[EV_APS_BIT] = k_change;
      event_set[EV_SOC_BIT] = pin_lvl_q[1];
      event_set[EV_PAR_LSB +: NUM_PORTS] = parity_check_en ? parity_error_in : 4'h0;
      event_set[EV_IDLE_BIT] = cell_hdr_valid && idle_match;
      event_set[EV_NOMATCH_BIT] = cell_hdr_valid && (port_match == 4'h0);
      event_set[EV_GFC_BIT] = cell_hdr_valid && (cell_hdr[31:28] != 4'h0);
      event_set[EV_LEN_BIT] = payload_len_error;
      event_set[EV_CRC_BIT] = payload_crc_error;
      event_set[EV_HEC_UNC_BIT] = hec_uncorrected;
      event_set[EV_HEC_COR_BIT] = hec_corrected;
   end

   // Bit 15 carries a condition only in the SONET/SDH mode; elsewhere it reads 0
   always_comb begin
      line_live = 16'hffff;
      unique case (line_mode)
         MODE_SONET: line_live[LINE_FEBE_BIT] = 1'b1;
         MODE_EXT_FRAMER, MODE_DS3, MODE_E3_G751, MODE_E3E4_G832: line_live[LINE_FEBE_BIT] = 1'b0;
         // Codes 5 to 7 name no mode and are handled like the non-SONET ones
         default: line_live[LINE_FEBE_BIT] = 1'b0;
      endcase
   end

   always_comb begin
      line_set = line_event_in & line_live;
      line_set[LINE_SEC_BIT] = one_second_tick;
      line_set[LINE_LOS_BIT] = pin_lvl_q[2];
   end

   // ==========================================================
   // Sticky status, write one to clear; a new event wins over the clear
   logic [15:0] line_clr, event_clr;
   assign line_clr = (wr_go && idx == IDX_LINE_ST) ? pwdata[15:0] : 16'h0000;
   assign event_clr = (wr_go && idx == IDX_EVENT_ST) ? pwdata[15:0] : 16'h0000;

   // Enables play no part here, so masked events are still recorded
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_st_q <= STATUS_RESET;
      end else begin
         line_st_q <= (line_st_q & ~line_clr) | line_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_st_q <= STATUS_RESET;
      end else begin
         event_st_q <= (event_st_q & ~event_clr) | event_set;
      end
   end

   // ==========================================================
   // Pending conditions, bit for bit status and enable
   logic [15:0] line_pend, event_pend, ovfl_pend, cell_pend;
   // Overflow and cell status arrive as levels from outside and are not latched here
   assign line_pend = line_st_q & line_en_q;
   assign event_pend = event_st_q & event_en_q;
   assign ovfl_pend = ovfl_status_in & ovfl_en_q;
   assign cell_pend = cell_status_in & cell_en_q;

   // ==========================================================
   // Shared interrupt output, one cycle behind the status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_int <= 1'b0;
      end else begin
         stat_int <= |{line_pend, event_pend, ovfl_pend, cell_pend};
      end
   end

endmodule : line_event_irq_enable

// *** testbench/line_event_irq_chk.sv ***
// Checker for APB timing and interrupt behaviour at the block ports
`timescale 1ns/1ps
module line_event_irq_chk
   import line_event_irq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic stat_int
);
   // ==========================================
   // Properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic setup = psel && !penable;
   ack_one_cycle_a: assert property (pready |=> !pready) else $error("pready too long");
   ack_after_setup_a: assert property (setup |=> pready) else $error("no pready after setup");
   ack_has_cause_a: assert property (pready |-> $past(setup)) else $error("pready without setup");
   err_with_ack_a: assert property (pslverr |-> pready) else $error("pslverr outside access");
   upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("prdata upper set");
   misalign_err_a: assert property (setup && paddr[1:0] != 2'b00 |=> pslverr) else $error("misaligned taken");
   gap_refused_a: assert property (setup && paddr[9:2] == 8'h31 |=> pslverr && prdata == 32'h0)
      else $error("gap index taken");
   event_rsvd_a: assert property (pready && !pwrite && paddr[9:2] == IDX_EVENT_EN |-> prdata[14:13] == 2'b00)
      else $error("reserved event bits set");
   irq_reset_low_a: assert property ($rose(presetn) |-> !stat_int) else $error("interrupt after reset");
   cover property (setup && pwrite);
   cover property (pslverr);
   cover property ($rose(stat_int));
endmodule : line_event_irq_chk
bind line_event_irq_enable line_event_irq_chk chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .stat_int(stat_int));

// *** testbench/apb_host.sv ***
// Host processor model issuing APB transfers
`timescale 1ns/1ps
module apb_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ==========================================
   // Bus cycle
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d, output logic [31:0] q,
      output logic e);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0, a == 12'h0b8 ? d & 16'h9fff : d};
      @(posedge pclk);
      penable <= 1;
      // Only the bench watchdog ends a wait that never gets an answer
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : xfer
endmodule : apb_host

// *** testbench/line_event_irq_enable_tb.sv ***
// Self-checking bench for the line/event interrupt enable block
`timescale 1ns/1ps
module line_event_irq_enable_tb;
   import line_event_irq_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stat_int, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, cell_hdr;
   logic receiver_hold_in, fifo_control_in_bit0, loss_of_signal_in, one_second_tick, rx_k_valid;
   logic cell_hdr_valid, payload_len_error, payload_crc_error, hec_uncorrected, hec_corrected;
   logic [15:0] line_event_in, ovfl_status_in, cell_status_in;
   logic [3:0] parity_error_in;
   logic [7:0] rx_k1_in, rx_k2_in;
   int failures, check_count, seed, b;
   int en[4], st[4];
   // ==========================================
   // Clock and instances
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end
   line_event_irq_enable line_event_irq_enable_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .receiver_hold_in, .fifo_control_in_bit0, .loss_of_signal_in,
      .one_second_tick, .line_event_in, .parity_error_in, .rx_k_valid, .rx_k1_in, .rx_k2_in, .cell_hdr_valid,
      .cell_hdr, .payload_len_error, .payload_crc_error, .hec_uncorrected, .hec_corrected, .ovfl_status_in,
      .cell_status_in, .stat_int);
   apb_host apb_host_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   // ==========================================
   // Model and helpers
   function automatic logic irq();
      return |((st[0] & en[0]) | (st[1] & en[1]) | (st[2] & en[2]) | (st[3] & en[3]));
   endfunction : irq
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic wr(input int a, input int d);
      apb_host_inst.xfer(1'b1, 12'(a * 4), 16'(d), q, err);
      if (a >= 'h2d && a <= 'h30) en[a - 'h2d] = d & (a == 'h2e ? 'h9fff : 'hffff);
      if (a == 'h38 || a == 'h39) st[a - 'h38] &= ~d;
   endtask : wr
   task automatic rd(input int a, input int e);
      apb_host_inst.xfer(1'b0, 12'(a * 4), 16'h0, q, err);
      cmp(q, 32'(e));
   endtask : rd
   task automatic irqchk;
      repeat (2) @(posedge pclk);
      cmp({31'h0, stat_int}, {31'h0, irq()});
   endtask : irqchk
   task automatic fire(input int c);
      @(posedge pclk);
      case (c)
         0: hec_corrected <= 1;
         1: hec_uncorrected <= 1;
         2: payload_crc_error <= 1;
         3: payload_len_error <= 1;
         4, 6: begin
            cell_hdr_valid <= 1;
            cell_hdr <= c == 4 ? 32'h5000_0000 : 32'h0;
         end
         11: fifo_control_in_bit0 <= 1;
         12: begin
            rx_k_valid <= 1;
            rx_k2_in <= rx_k2_in ^ 8'h01;
         end
         15: receiver_hold_in <= 1;
         16: begin
            one_second_tick <= 1;
            loss_of_signal_in <= 1;
            line_event_in <= 16'h8020;
         end
         default: parity_error_in <= 4'(1 << (c - 7));
      endcase
      // Pins must stand at least two clocks to pass the synchroniser
      repeat (4) @(posedge pclk);
      {hec_corrected, hec_uncorrected, payload_crc_error, payload_len_error, cell_hdr_valid} <= '0;
      {fifo_control_in_bit0, rx_k_valid, receiver_hold_in, one_second_tick, loss_of_signal_in} <= '0;
      {parity_error_in, line_event_in} <= '0;
      // Pins cross a three-stage synchroniser first
      repeat (8) @(posedge pclk);
   endtask : fire
   task automatic results;
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   // ==========================================
   // Tests
   initial begin
      #100us;
      failures++;
      results;
   end
   initial begin
      seed = 32'h96229319;
      presetn = 0;
      {receiver_hold_in, fifo_control_in_bit0, loss_of_signal_in, one_second_tick, rx_k_valid} = '0;
      {cell_hdr_valid, payload_len_error, payload_crc_error, hec_uncorrected, hec_corrected} = '0;
      {line_event_in, ovfl_status_in, cell_status_in, parity_error_in, rx_k1_in, rx_k2_in, cell_hdr} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1;
      foreach (en[i]) rd('h2d + i, 0);
      apb_host_inst.xfer(0, 12'h0c4, 0, q, err);
      cmp(err, 1);
      apb_host_inst.xfer(1, 12'h0b5, 0, q, err);
      cmp(err, 1);
      foreach (en[i]) begin
         wr('h2d + i, $random(seed));
         rd('h2d + i, en[i]);
      end
      $display("register test done");
      rx_k1_in <= 8'($random(seed));
      rx_k2_in <= 8'($random(seed));
      rx_k_valid <= 1;
      @(posedge pclk) rx_k_valid <= 0;
      rd('h33, {rx_k1_in, rx_k2_in});
      wr('h40, 0);
      fire(8);
      rd('h39, 0);
      wr('h40, 'h8);
      for (b = 0; b < 16; b++) begin
         if (b == 5 || b == 13 || b == 14) continue;
         wr('h2e, 0);
         fire(b);
         st[1] |= b == 4 ? 'h30 : 1 << b;
         rd('h39, st[1]);
         irqchk;
         wr('h2e, 1 << b);
         irqchk;
         wr('h39, 'hffff);
         irqchk;
      end
      wr('h15, 'h5000);
      rd('h15, 'h5000);
      wr('h27, 'hffff);
      wr('h28, 'hffff);
      fire(4);
      st[1] = 'h50;
      rd('h39, st[1]);
      wr('h39, 'hffff);
      $display("event test done");
      fire(16);
      st[0] = 'h4021;
      rd('h38, st[0]);
      wr('h40, 'hb);
      fire(16);
      st[0] = 'hc021;
      rd('h38, st[0]);
      wr('h2d, 'h4000);
      irqchk;
      wr('h2d, 0);
      $display("line test done");
      ovfl_status_in <= 16'h0100;
      cell_status_in <= 16'h0002;
      st[2] = 'h100;
      st[3] = 'h2;
      wr('h2f, 'h100);
      irqchk;
      wr('h2f, 'hfeff);
      wr('h30, 0);
      irqchk;
      wr('h30, 'h2);
      irqchk;
      $display("shared output test done");
      results;
   end
endmodule : line_event_irq_enable_tb
